//--- rtl/charger_command_register_bank.sv
// Charger command register bank behind a two-wire word-transfer slave.
// Assumes SCL/SDA and the comparator levels arrive asynchronously;
// SDA is open drain, resolved outside from SDA_OE.
`timescale 1ns/1ps
`include "charger_defs.svh"

// Function
// - Six command registers, word read; word write to all but the two identity ones
// - Identity reads return fixed constants
// - Option word read/write, resets 7904h
// - Fill current: 7-bit, resets zero
// - Target voltage: 11-bit, resets zero
// - Draw limit: 6-bit, resets 1000h
// - Option bit 15 picks deglitch interval
// - Watchdog expiry suspends charging
// - Current or voltage write resumes charging
// - Bit 10 picks frequency shift direction
// - Bit 9 enables frequency shift
// - Bits 8:7 pick short-circuit threshold
// - Bit 5 routes current monitor source
// - Bits 2:1 pick adapter overcurrent level
// - Bit 0 inhibits charging
// - Slave only, fixed address 12h
// - Out-of-range current write clears, stops
// - Out-of-range voltage write clears, stops
module charger_command_register_bank #(
	parameter logic [31:0] DGL_LONG_CYC = `DGL_LONG_CYC,
	parameter logic [31:0] CYC_PER_SEC = `CYC_PER_SEC,
	parameter logic [15:0] MAKER_ID = `MAKER_ID_VALUE,
	parameter logic [15:0] PART_ID = `PART_ID_VALUE
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic SUPPLY_LOCKOUT_LEVEL,
	input wire logic ADAPTER_DETECT_INPUT,
	output logic ADAPTER_PRESENT_FLAG,
	output logic CHARGE_ENABLE,
	output logic [6:0] FILL_CURRENT_SET,
	output logic [10:0] TARGET_VOLTAGE_SET,
	output logic [5:0] DRAW_LIMIT_SET,
	output logic FREQ_SHIFT_ENABLE,
	output logic FREQ_SHIFT_UP,
	output logic [1:0] HIGH_SIDE_SHORT_COMPARATOR_SEL,
	output logic CURRENT_MONITOR_OUTPUT_SEL,
	output logic [1:0] ADAPTER_OVERCURRENT_PROTECT_SEL
);
	// ==========================================================
	// Declarations
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic scl_d_reg;
	logic sda_d_reg;
	logic scl_s, sda_s, bus_en;
	logic start_cond, stop_cond, scl_rise, scl_fall;
	charger_pkg::bus_state_t state_reg;
	logic ack_phase_reg, slave_ack_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg, cmd_reg, wlo_reg, tx_reg, thi_reg;
	logic got_cmd_reg;
	logic wr_pulse_reg;
	logic [15:0] wr_data_reg;
	logic [15:0] option_reg, fill_reg, volt_reg, draw_reg;
	logic [31:0] dgl_cnt_reg, dgl_limit;
	logic [15:0] rd_word;
	logic [6:0] fill_field;
	logic [10:0] volt_field;
	logic fill_write, volt_write, wdt_expired;

	// ==========================================================
	// Functions
	// Only documented codes are acknowledged
	function automatic logic cmd_known(input logic [7:0] c);
		case (c)
			`CMD_OPTION, `CMD_FILL_CURRENT, `CMD_TARGET_VOLTAGE, `CMD_DRAW_LIMIT,
			`CMD_MAKER_ID, `CMD_PART_ID: cmd_known = 1'b1;
			default: cmd_known = 1'b0;
		endcase
	endfunction

	function automatic logic [15:0] read_word(input logic [7:0] c);
		case (c)
			`CMD_OPTION: read_word = option_reg;
			`CMD_FILL_CURRENT: read_word = fill_reg;
			`CMD_TARGET_VOLTAGE: read_word = volt_reg;
			`CMD_DRAW_LIMIT: read_word = draw_reg;
			`CMD_MAKER_ID: read_word = MAKER_ID;
			`CMD_PART_ID: read_word = PART_ID;
			default: read_word = 16'h0000;
		endcase
	endfunction

	// ==========================================================
	// Pin synchronisers: SCL, SDA, lockout, detect
	always_ff @(posedge CLK) begin
		if (RST) begin
			sync1_reg <= 4'hF;
			sync2_reg <= 4'hF;
		end else begin
			sync1_reg <= {ADAPTER_DETECT_INPUT, SUPPLY_LOCKOUT_LEVEL, SDA_IN, SCL};
			sync2_reg <= sync1_reg;
		end
	end
	assign scl_s = sync2_reg[0];
	assign sda_s = sync2_reg[1];
	// Bus answers only above lockout and with the detect comparator high
	assign bus_en = sync2_reg[2] & sync2_reg[3];

	always_ff @(posedge CLK) begin
		if (RST) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end
	assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	assign scl_rise = scl_s & ~scl_d_reg;
	assign scl_fall = ~scl_s & scl_d_reg;
	assign rd_word = read_word(cmd_reg);

	// ==========================================================
	// Byte engine; the device never masters the bus
	always_ff @(posedge CLK) begin
		if (RST || !bus_en || stop_cond) begin
			state_reg <= charger_pkg::ST_IDLE;
			ack_phase_reg <= 1'b0;
			slave_ack_reg <= 1'b0;
			bit_cnt_reg <= 4'h0;
			SDA_OE <= 1'b0;
			wr_pulse_reg <= 1'b0;
		end else if (start_cond) begin
			state_reg <= charger_pkg::ST_ADDR;
			ack_phase_reg <= 1'b0;
			slave_ack_reg <= 1'b0;
			bit_cnt_reg <= 4'h0;
			SDA_OE <= 1'b0;
			wr_pulse_reg <= 1'b0;
		end else begin
			wr_pulse_reg <= 1'b0;
			if (scl_rise && !ack_phase_reg) begin
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
			if (scl_rise && ack_phase_reg && !slave_ack_reg) begin
				// Master acknowledge of a read byte
				if (sda_s || state_reg == charger_pkg::ST_TX_HI) begin
					state_reg <= charger_pkg::ST_SKIP;
					ack_phase_reg <= 1'b0;
				end else begin
					state_reg <= charger_pkg::ST_TX_HI;
				end
			end else if (scl_fall && ack_phase_reg) begin
				ack_phase_reg <= 1'b0;
				slave_ack_reg <= 1'b0;
				bit_cnt_reg <= 4'h0;
				SDA_OE <= (state_reg == charger_pkg::ST_TX_LO ||
					state_reg == charger_pkg::ST_TX_HI) ? ~tx_reg[7] : 1'b0;
			end else if (scl_fall) begin
				case (state_reg)
					charger_pkg::ST_ADDR, charger_pkg::ST_CMD,
					charger_pkg::ST_WLO, charger_pkg::ST_WHI: begin
						if (bit_cnt_reg == 4'h8) begin
							ack_phase_reg <= 1'b1;
							slave_ack_reg <= 1'b1;
							SDA_OE <= 1'b1;
							case (state_reg)
								charger_pkg::ST_ADDR: begin
									if (shift_reg[7:1] != `SLAVE_ADDR7) begin
										state_reg <= charger_pkg::ST_SKIP;
										ack_phase_reg <= 1'b0;
										slave_ack_reg <= 1'b0;
										SDA_OE <= 1'b0;
									end else if (!shift_reg[0]) begin
										state_reg <= charger_pkg::ST_CMD;
									end else if (got_cmd_reg) begin
										state_reg <= charger_pkg::ST_TX_LO;
									end else begin
										state_reg <= charger_pkg::ST_SKIP;
										ack_phase_reg <= 1'b0;
										slave_ack_reg <= 1'b0;
										SDA_OE <= 1'b0;
									end
								end
								charger_pkg::ST_CMD: begin
									if (cmd_known(shift_reg)) begin
										state_reg <= charger_pkg::ST_WLO;
									end else begin
										state_reg <= charger_pkg::ST_SKIP;
										ack_phase_reg <= 1'b0;
										slave_ack_reg <= 1'b0;
										SDA_OE <= 1'b0;
									end
								end
								charger_pkg::ST_WLO: state_reg <= charger_pkg::ST_WHI;
								default: begin
									state_reg <= charger_pkg::ST_SKIP;
									wr_pulse_reg <= 1'b1;
								end
							endcase
						end
					end
					charger_pkg::ST_TX_LO, charger_pkg::ST_TX_HI: begin
						if (bit_cnt_reg == 4'h8) begin
							SDA_OE <= 1'b0;
							ack_phase_reg <= 1'b1;
						end else begin
							SDA_OE <= ~tx_reg[3'(4'h7 - bit_cnt_reg)];
						end
					end
					default: SDA_OE <= 1'b0;
				endcase
			end
		end
	end

	// ==========================================================
	// Byte capture and read data staging
	always_ff @(posedge CLK) begin
		if (RST) begin
			shift_reg <= 8'h00;
			cmd_reg <= 8'h00;
			wlo_reg <= 8'h00;
			got_cmd_reg <= 1'b0;
			tx_reg <= 8'h00;
			thi_reg <= 8'h00;
			wr_data_reg <= 16'h0000;
		end else begin
			if (start_cond && state_reg != charger_pkg::ST_TX_LO) begin
				got_cmd_reg <= got_cmd_reg & (state_reg == charger_pkg::ST_WLO);
			end
			if (scl_rise && !ack_phase_reg) begin
				shift_reg <= {shift_reg[6:0], sda_s};
			end
			if (scl_fall && !ack_phase_reg && bit_cnt_reg == 4'h8) begin
				case (state_reg)
					charger_pkg::ST_CMD: begin
						cmd_reg <= shift_reg;
						got_cmd_reg <= cmd_known(shift_reg);
					end
					charger_pkg::ST_WLO: wlo_reg <= shift_reg;
					charger_pkg::ST_WHI: wr_data_reg <= {shift_reg, wlo_reg};
					charger_pkg::ST_ADDR: begin
						// Word is frozen here so both bytes are coherent
						tx_reg <= rd_word[7:0];
						thi_reg <= rd_word[15:8];
					end
					default: shift_reg <= shift_reg;
				endcase
			end
			if (scl_rise && ack_phase_reg && !slave_ack_reg && !sda_s) begin
				tx_reg <= thi_reg;
			end
		end
	end

	// ==========================================================
	// Command registers
	assign fill_field = wr_data_reg[`FILL_LSB +: 7];
	assign volt_field = wr_data_reg[`VOLT_LSB +: 11];
	assign fill_write = wr_pulse_reg && cmd_reg == `CMD_FILL_CURRENT;
	assign volt_write = wr_pulse_reg && cmd_reg == `CMD_TARGET_VOLTAGE;

	always_ff @(posedge CLK) begin
		if (RST) begin
			option_reg <= `OPTION_RESET;
		end else if (wr_pulse_reg && cmd_reg == `CMD_OPTION) begin
			option_reg <= (wr_data_reg & `OPTION_WMASK) |
				(`OPTION_RESET & ~`OPTION_WMASK);
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			fill_reg <= `FILL_CURRENT_RESET;
		end else if (fill_write) begin
			if (fill_field < `FILL_MIN || (wr_data_reg & ~16'h1FFF) != 16'h0000) begin
				fill_reg <= 16'h0000;
			end else begin
				fill_reg <= wr_data_reg & `FILL_CURRENT_MASK;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			volt_reg <= `TARGET_VOLTAGE_RESET;
		end else if (volt_write) begin
			if (volt_field < `VOLT_MIN || volt_field > `VOLT_MAX || wr_data_reg[15]) begin
				volt_reg <= 16'h0000;
			end else begin
				volt_reg <= wr_data_reg & `TARGET_VOLTAGE_MASK;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			draw_reg <= `DRAW_LIMIT_RESET;
		end else if (wr_pulse_reg && cmd_reg == `CMD_DRAW_LIMIT) begin
			draw_reg <= wr_data_reg & `DRAW_LIMIT_MASK;
		end
	end

	// ==========================================================
	// Write watchdog
	write_watchdog #(
		.CYC_PER_SEC(CYC_PER_SEC)
	) write_watchdog_inst (
		.CLK(CLK),
		.RST(RST),
		.SEL(charger_pkg::wdt_sel_t'(option_reg[`OPT_WDT_HI:`OPT_WDT_LO])),
		.KICK(fill_write || volt_write),
		.EXPIRED(wdt_expired)
	);

	// ==========================================================
	// Adapter-present deglitch: rising edge is filtered, falling is immediate
	assign dgl_limit = option_reg[`OPT_DEGLITCH_MIN] ?
		32'(`DGL_SHORT_CYC) : DGL_LONG_CYC;

	always_ff @(posedge CLK) begin
		if (RST || !sync2_reg[3]) begin
			dgl_cnt_reg <= 32'h0000_0000;
			ADAPTER_PRESENT_FLAG <= 1'b0;
		end else if (dgl_cnt_reg >= dgl_limit) begin
			ADAPTER_PRESENT_FLAG <= 1'b1;
		end else begin
			dgl_cnt_reg <= dgl_cnt_reg + 32'h0000_0001;
		end
	end

	// ==========================================================
	// Outputs to the power stage
	always_ff @(posedge CLK) begin
		if (RST) begin
			CHARGE_ENABLE <= 1'b0;
			FILL_CURRENT_SET <= 7'h00;
			TARGET_VOLTAGE_SET <= 11'h000;
			DRAW_LIMIT_SET <= 6'h00;
			FREQ_SHIFT_ENABLE <= 1'b0;
			FREQ_SHIFT_UP <= 1'b0;
			HIGH_SIDE_SHORT_COMPARATOR_SEL <= 2'h0;
			CURRENT_MONITOR_OUTPUT_SEL <= 1'b0;
			ADAPTER_OVERCURRENT_PROTECT_SEL <= 2'h0;
		end else begin
			// Zeroed settings mean no charge, which is how a bad write stops it
			CHARGE_ENABLE <= !option_reg[`OPT_INHIBIT] && !wdt_expired &&
				fill_reg != 16'h0000 && volt_reg != 16'h0000 &&
				ADAPTER_PRESENT_FLAG;
			FILL_CURRENT_SET <= fill_reg[`FILL_LSB +: 7];
			TARGET_VOLTAGE_SET <= volt_reg[`VOLT_LSB +: 11];
			DRAW_LIMIT_SET <= draw_reg[`DRAW_LSB +: 6];
			FREQ_SHIFT_ENABLE <= option_reg[`OPT_FREQ_EN];
			FREQ_SHIFT_UP <= option_reg[`OPT_FREQ_UP];
			HIGH_SIDE_SHORT_COMPARATOR_SEL <= option_reg[`OPT_SHORT_HI:`OPT_SHORT_LO];
			CURRENT_MONITOR_OUTPUT_SEL <= option_reg[`OPT_MON_SEL];
			ADAPTER_OVERCURRENT_PROTECT_SEL <= option_reg[`OPT_OVERCUR_HI:`OPT_OVERCUR_LO];
		end
	end

	// Open drain: only ever pulls low
	always_ff @(posedge CLK) begin
		SDA_OUT <= 1'b0;
	end
endmodule // charger_command_register_bank

//--- include/charger_defs.svh
// Constants of the charger command register bank.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef CHARGER_DEFS_SVH
`define CHARGER_DEFS_SVH

// ==========================================================
// Bus address and command codes
`define SLAVE_ADDR7 7'h09
`define CMD_OPTION 8'h12
`define CMD_FILL_CURRENT 8'h14
`define CMD_TARGET_VOLTAGE 8'h15
`define CMD_DRAW_LIMIT 8'h3F
`define CMD_MAKER_ID 8'hFE
`define CMD_PART_ID 8'hFF

// ==========================================================
// Reset values and write masks
`define OPTION_RESET 16'h7904
`define OPTION_WMASK 16'hE7A7
`define FILL_CURRENT_RESET 16'h0000
`define TARGET_VOLTAGE_RESET 16'h0000
`define DRAW_LIMIT_RESET 16'h1000
`define FILL_CURRENT_MASK 16'h1FC0
`define TARGET_VOLTAGE_MASK 16'h7FF0
`define DRAW_LIMIT_MASK 16'h1F80
// Identity values are arbitrary
`define MAKER_ID_VALUE 16'h5A01
`define PART_ID_VALUE 16'h00C3

// ==========================================================
// Field positions
`define FILL_LSB 6
`define VOLT_LSB 4
`define DRAW_LSB 7
`define OPT_DEGLITCH_MIN 15
`define OPT_WDT_HI 14
`define OPT_WDT_LO 13
`define OPT_FREQ_UP 10
`define OPT_FREQ_EN 9
`define OPT_SHORT_HI 8
`define OPT_SHORT_LO 7
`define OPT_MON_SEL 5
`define OPT_OVERCUR_HI 2
`define OPT_OVERCUR_LO 1
`define OPT_INHIBIT 0

// ==========================================================
// Legal ranges in field steps (64 mA and 16 mV)
`define FILL_MIN 7'h02
`define VOLT_MIN 11'h040
`define VOLT_MAX 11'h4B0

// ==========================================================
// Timing
`define CLK_MHZ 100
`define CYC_PER_SEC (32'h05F5_E100)
`define DGL_LONG_MS 1300
`define DGL_SHORT_US 50
`define DGL_LONG_CYC (`DGL_LONG_MS * `CLK_MHZ * 1000)
`define DGL_SHORT_CYC (`DGL_SHORT_US * `CLK_MHZ - 1)
`define WDT_44_S 8'h2C
`define WDT_88_S 8'h58
`define WDT_175_S 8'hAF

`endif

//--- include/charger_pkg.sv
// Types of the charger command register bank.
// Assumes the constants header is compiled alongside.
package charger_pkg;
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_CMD,
		ST_WLO,
		ST_WHI,
		ST_TX_LO,
		ST_TX_HI,
		ST_SKIP
	} bus_state_t;

	typedef enum logic [1:0] {
		WDT_OFF,
		WDT_SHORT,
		WDT_MID,
		WDT_LONG
	} wdt_sel_t;
endpackage

//--- rtl/write_watchdog.sv
// Write watchdog: suspends charging when settings are not refreshed.
// Assumes kick is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`include "charger_defs.svh"

module write_watchdog #(
	parameter logic [31:0] CYC_PER_SEC = `CYC_PER_SEC
) (
	input wire logic CLK,
	input wire logic RST,
	input wire charger_pkg::wdt_sel_t SEL,
	input wire logic KICK,
	output logic EXPIRED
);
	logic [31:0] prescale_reg;
	logic [7:0] seconds_reg;
	logic [7:0] limit;

	// ==========================================================
	// Period select
	always_comb begin
		case (SEL)
			charger_pkg::WDT_SHORT: limit = `WDT_44_S;
			charger_pkg::WDT_MID: limit = `WDT_88_S;
			charger_pkg::WDT_LONG: limit = `WDT_175_S;
			default: limit = 8'h00;
		endcase
	end

	// ==========================================================
	// Counter; a write both clears expiry and restarts the period
	always_ff @(posedge CLK) begin
		if (RST || KICK || SEL == charger_pkg::WDT_OFF) begin
			prescale_reg <= 32'h0000_0000;
			seconds_reg <= 8'h00;
		end else if (!EXPIRED) begin
			if (prescale_reg == CYC_PER_SEC - 32'h0000_0001) begin
				prescale_reg <= 32'h0000_0000;
				seconds_reg <= seconds_reg + 8'h01;
			end else begin
				prescale_reg <= prescale_reg + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RST || KICK || SEL == charger_pkg::WDT_OFF) begin
			EXPIRED <= 1'b0;
		end else if (seconds_reg >= limit) begin
			EXPIRED <= 1'b1;
		end
	end
endmodule // write_watchdog

//--- verification/charger_bank_checker.sv
// Checker for the charger command register bank, port level only.
// Assumes it is bound to the bank's top module on one clock domain.
`timescale 1ns/1ps

// ==========================================================
// Assertions
module charger_bank_checker #(
	parameter logic [31:0] DGL_LONG_CYC = 32'h0000_0032
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic SCL,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	input wire logic SUPPLY_LOCKOUT_LEVEL,
	input wire logic ADAPTER_DETECT_INPUT,
	input wire logic ADAPTER_PRESENT_FLAG,
	input wire logic CHARGE_ENABLE,
	input wire logic [6:0] FILL_CURRENT_SET,
	input wire logic [10:0] TARGET_VOLTAGE_SET,
	input wire logic [5:0] DRAW_LIMIT_SET,
	input wire logic FREQ_SHIFT_ENABLE,
	input wire logic FREQ_SHIFT_UP,
	input wire logic [1:0] HIGH_SIDE_SHORT_COMPARATOR_SEL,
	input wire logic CURRENT_MONITOR_OUTPUT_SEL,
	input wire logic [1:0] ADAPTER_OVERCURRENT_PROTECT_SEL
);
	logic [31:0] hi_cnt;

	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	// Run length of detect high; saturates so a long run never wraps
	always_ff @(posedge CLK) begin
		if (RST || !ADAPTER_DETECT_INPUT) begin
			hi_cnt <= 32'h0000_0000;
		end else if (hi_cnt != 32'hFFFF_FFFF) begin
			hi_cnt <= hi_cnt + 32'h0000_0001;
		end
	end

	// Eight edges covers the pin synchronisers and the output register
	sequence s_bus_idle;
		SCL [*8];
	endsequence

	sequence s_bus_off;
		(!SUPPLY_LOCKOUT_LEVEL || !ADAPTER_DETECT_INPUT) [*4];
	endsequence

	a_open_drain_low: assert property (SDA_OE |-> !SDA_OUT)
		else $error("data pin driven high");
	a_reset_defaults: assert property ($fell(RST) |-> ##2
		(HIGH_SIDE_SHORT_COMPARATOR_SEL == 2'h2 && ADAPTER_OVERCURRENT_PROTECT_SEL == 2'h2
		&& DRAW_LIMIT_SET == 6'h20 && FILL_CURRENT_SET == 7'h00 && !FREQ_SHIFT_ENABLE))
		else $error("settings wrong after reset");
	a_fill_zero_off: assert property ((FILL_CURRENT_SET == 7'h00) [*2] |-> !CHARGE_ENABLE)
		else $error("charging with zero current");
	a_volt_zero_off: assert property ((TARGET_VOLTAGE_SET == 11'h000) [*2] |-> !CHARGE_ENABLE)
		else $error("charging with zero voltage");
	a_detect_drop: assert property (!ADAPTER_DETECT_INPUT [*4] |-> !ADAPTER_PRESENT_FLAG)
		else $error("present flag held without adapter");
	a_deglitch_min: assert property ($rose(ADAPTER_PRESENT_FLAG) |-> hi_cnt >= DGL_LONG_CYC)
		else $error("present flag rose too early");
	a_bus_off_quiet: assert property (s_bus_off |-> !SDA_OE)
		else $error("bus answered while disabled");
	a_settings_hold: assert property (s_bus_idle |-> $stable({FILL_CURRENT_SET,
		TARGET_VOLTAGE_SET, DRAW_LIMIT_SET, FREQ_SHIFT_ENABLE, FREQ_SHIFT_UP,
		HIGH_SIDE_SHORT_COMPARATOR_SEL, CURRENT_MONITOR_OUTPUT_SEL,
		ADAPTER_OVERCURRENT_PROTECT_SEL}))
		else $error("settings changed without a transfer");
	a_drive_clock_low: assert property ($changed(SDA_OE) |-> !SCL)
		else $error("data pin changed while clock high");
endmodule // charger_bank_checker

bind charger_command_register_bank charger_bank_checker #(
	.DGL_LONG_CYC(DGL_LONG_CYC)
) charger_bank_checker_inst (
	.CLK, .RST, .SCL, .SDA_IN, .SDA_OUT, .SDA_OE, .SUPPLY_LOCKOUT_LEVEL,
	.ADAPTER_DETECT_INPUT, .ADAPTER_PRESENT_FLAG, .CHARGE_ENABLE, .FILL_CURRENT_SET,
	.TARGET_VOLTAGE_SET, .DRAW_LIMIT_SET, .FREQ_SHIFT_ENABLE, .FREQ_SHIFT_UP,
	.HIGH_SIDE_SHORT_COMPARATOR_SEL, .CURRENT_MONITOR_OUTPUT_SEL,
	.ADAPTER_OVERCURRENT_PROTECT_SEL
);

//--- verification/charger_host_model.sv
// Host controller model: word write and word read as bus master.
// Assumes the data wire is resolved outside with a pull-up.
`timescale 1ns/1ps

// ==========================================================
// Bus master
module charger_host_model #(
	parameter int HALF = 15
) (
	input wire logic CLK,
	input wire logic SDA_LINE,
	output logic SCL,
	output logic SDA_PULL
);
	initial begin
		SCL = 1'b1;
		SDA_PULL = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge CLK);
	endtask

	// Data moves two edges after the clock falls, never with it
	task automatic put_bit(input logic b);
		tick(2);
		SDA_PULL = !b;
		tick(HALF);
		SCL = 1'b1;
		tick(HALF);
		SCL = 1'b0;
	endtask

	task automatic get_bit(output logic b);
		tick(2);
		SDA_PULL = 1'b0;
		tick(HALF);
		b = SDA_LINE;
		SCL = 1'b1;
		tick(HALF);
		SCL = 1'b0;
	endtask

	// Serves as first and repeated start alike
	task automatic start;
		tick(2);
		SDA_PULL = 1'b0;
		tick(HALF);
		SCL = 1'b1;
		tick(HALF);
		SDA_PULL = 1'b1;
		tick(HALF);
		SCL = 1'b0;
	endtask

	task automatic stop;
		tick(2);
		SDA_PULL = 1'b1;
		tick(HALF);
		SCL = 1'b1;
		tick(HALF);
		SDA_PULL = 1'b0;
		tick(HALF);
	endtask

	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i]);
		end
		get_bit(b);
		ack = !b;
	endtask

	task automatic get_byte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			get_bit(d[i]);
		end
		put_bit(last);
	endtask

	// Low byte first, whole word within one frame
	task automatic write_word(input logic [7:0] adr, input logic [7:0] cmd,
		input logic [15:0] data, output logic ok);
		logic k;
		start();
		put_byte(adr, ok);
		put_byte(cmd, k);
		ok = ok && k;
		put_byte(data[7:0], k);
		ok = ok && k;
		put_byte(data[15:8], k);
		ok = ok && k;
		stop();
	endtask

	task automatic read_word(input logic [7:0] cmd, output logic [15:0] data,
		output logic ok);
		logic k;
		start();
		put_byte(8'h12, ok);
		put_byte(cmd, k);
		ok = ok && k;
		start();
		put_byte(8'h13, k);
		ok = ok && k;
		get_byte(1'b0, data[7:0]);
		get_byte(1'b1, data[15:8]);
		stop();
	endtask
endmodule // charger_host_model

//--- verification/charger_command_register_bank_tb.sv
// Testbench for the charger command register bank through the host model.
// Assumes the checker and host model files are compiled before it.
`timescale 1ns/1ps

// ==========================================================
// Bench
module charger_command_register_bank_tb;
	localparam logic [15:0] MAKER_CODE = 16'hA5C3; // Arbitrary identity value
	localparam logic [15:0] PART_CODE = 16'h3C5A; // Arbitrary identity value
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic lockout_ok = 1'b1;
	logic detect = 1'b1;
	logic scl, host_pull, sda_out, sda_oe, present, charge_en, freq_en, freq_up, mon_sel;
	logic sda_line;
	logic [6:0] fill;
	logic [10:0] volt;
	logic [5:0] draw;
	logic [1:0] short_sel, overcur_sel;
	int failures = 0;
	int num_checks = 0;
	logic [7:0] cmds [6] = '{8'h12, 8'h14, 8'h15, 8'h3F, 8'hFE, 8'hFF};
	logic [15:0] dflt [6] = '{16'h7904, 16'h0000, 16'h0000, 16'h1000, MAKER_CODE, PART_CODE};
	// Command, written word, word read back; fill and voltage end legal
	logic [39:0] wtab [11] = '{{8'h12, 16'hFFFF, 16'hFFA7}, {8'h14, 16'h0040, 16'h0000},
		{8'h14, 16'hE080, 16'h0000}, {8'h14, 16'h1FC5, 16'h1FC0}, {8'h15, 16'h4B10, 16'h0000},
		{8'h15, 16'h03F0, 16'h0000}, {8'h15, 16'h0400, 16'h0400}, {8'h15, 16'h4B00, 16'h4B00},
		{8'h3F, 16'hFFFF, 16'h1F80}, {8'hFE, 16'h1234, MAKER_CODE}, {8'hFF, 16'h1234, PART_CODE}};

	assign sda_line = !(host_pull || sda_oe === 1'b1);
	always #5 clk = ~clk;

	charger_command_register_bank #(.DGL_LONG_CYC(32'h0000_0032), .CYC_PER_SEC(32'h0000_0064),
		.MAKER_ID(MAKER_CODE), .PART_ID(PART_CODE)) charger_command_register_bank_inst (
		.CLK(clk), .RST(rst), .SCL(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.SUPPLY_LOCKOUT_LEVEL(lockout_ok), .ADAPTER_DETECT_INPUT(detect),
		.ADAPTER_PRESENT_FLAG(present), .CHARGE_ENABLE(charge_en), .FILL_CURRENT_SET(fill),
		.TARGET_VOLTAGE_SET(volt), .DRAW_LIMIT_SET(draw), .FREQ_SHIFT_ENABLE(freq_en),
		.FREQ_SHIFT_UP(freq_up), .HIGH_SIDE_SHORT_COMPARATOR_SEL(short_sel),
		.CURRENT_MONITOR_OUTPUT_SEL(mon_sel), .ADAPTER_OVERCURRENT_PROTECT_SEL(overcur_sel));

	charger_host_model host_inst (.CLK(clk), .SDA_LINE(sda_line), .SCL(scl), .SDA_PULL(host_pull));

	task automatic close_out;
		if (failures == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic check_pin(input logic [10:0] got, input logic [10:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: pins %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
		logic ok;
		host_inst.write_word(8'h12, cmd, d, ok);
		check_pin(11'(ok), 11'h001);
	endtask

	task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
		logic [15:0] d;
		logic ok;
		host_inst.read_word(cmd, d, ok);
		check_pin(11'(ok), 11'h001);
		check_word(d, exp);
	endtask

	// Run needs about 75k cycles; reaching 95k means a hang
	initial begin
		#950_000;
		failures++;
		close_out();
	end

	initial begin
		logic [15:0] d;
		logic ok;
		int i;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (100) @(negedge clk);
		check_pin(11'(present), 11'h001);
		check_pin(11'({short_sel, overcur_sel, freq_en, freq_up, mon_sel, charge_en}), 11'h0A0);
		check_pin(11'(sda_out), 11'h000);
		for (i = 0; i < 6; i++) begin
			rd(cmds[i], dflt[i]);
		end
		for (i = 0; i < 4; i++) begin
			d = (16'(i) << 13) | (16'(i) << 7) | (16'(i) << 1);
			// Shift direction apart from its enable, so a swap shows
			d = d | (16'(i % 2) << 10) | (16'(i / 2) << 5);
			wr(8'h12, d);
			rd(8'h12, d | 16'h1800);
			check_pin(11'({short_sel, overcur_sel}), 11'(i * 5));
			check_pin(11'({freq_en, freq_up, mon_sel}), 11'(i % 2 * 2 + i / 2));
		end
		for (i = 0; i < 11; i++) begin
			wr(wtab[i][39:32], wtab[i][31:16]);
			rd(wtab[i][39:32], wtab[i][15:0]);
		end
		check_pin({fill, draw[3:0]}, {7'h7F, 4'hF});
		check_pin(volt, 11'h4B0);
		check_pin(11'({short_sel, overcur_sel, freq_en, freq_up, mon_sel, charge_en}), 11'h0FE);
		host_inst.write_word(8'h14, 8'h12, 16'h0000, ok);
		check_pin(11'(ok), 11'h000);
		host_inst.write_word(8'h12, 8'h13, 16'h0000, ok);
		check_pin(11'(ok), 11'h000);
		lockout_ok = 1'b0;
		repeat (5) @(negedge clk);
		host_inst.write_word(8'h12, 8'h12, 16'h0000, ok);
		check_pin(11'(ok), 11'h000);
		lockout_ok = 1'b1;
		repeat (5) @(negedge clk);
		rd(8'h12, 16'hFFA7);
		wr(8'h12, 16'h2000);
		wr(8'h15, 16'h4B00);
		check_pin(11'(charge_en), 11'h001);
		repeat (3500) @(negedge clk);
		check_pin(11'(charge_en), 11'h001);
		repeat (1000) @(negedge clk);
		check_pin(11'(charge_en), 11'h000);
		wr(8'h14, 16'h0080);
		check_pin(11'(charge_en), 11'h001);
		wr(8'h14, 16'h0040);
		check_pin(11'(charge_en), 11'h000);
		// Bit 15 is changed only while the bus is enabled
		wr(8'h12, 16'h8000);
		rd(8'h12, 16'h9800);
		detect = 1'b0;
		repeat (10) @(negedge clk);
		check_pin(11'(present), 11'h000);
		detect = 1'b1;
		repeat (60) @(negedge clk);
		check_pin(11'(present), 11'h000);
		i = 0;
		while (present !== 1'b1 && i < 5100) begin
			@(negedge clk);
			i++;
		end
		check_pin(11'(present), 11'h001);
		close_out();
	end
endmodule // charger_command_register_bank_tb
